// file: hw/rts_top.sv
// reset and start-up sequencer with power status register
// expects synchronous inputs, classic wishbone master, 20 MHz clk
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module rts_top #(
  parameter int unsigned POWERUP_DELAY_TIMER_TICKS  = rts_pkg::POWERUP_DELAY_TIMER_TICKS,
  parameter int unsigned RC_DIV      = rts_pkg::RC_DIV,
  parameter int unsigned OST_CYC     = rts_pkg::OST_CYC,
  parameter int unsigned FILT_CYC    = rts_pkg::FILT_CYC,
  parameter int unsigned BOD_MIN_CYC = rts_pkg::BOD_MIN_CYC
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire rts_pkg::rts_mode_e osc_mode_i,
  input  wire logic        powerup_delay_disable_n,
  input  wire logic        brownout_enable,
  input  wire logic        external_reset_pin_enable,
  input  wire logic        external_reset_n,
  input  wire logic        vdd_por_ok_i,
  input  wire logic        vdd_above_bod_i,
  input  wire logic        wdt_reset_i,
  input  wire logic        sleep_wake_i,
  input  wire logic        osc1_i,
  input  wire logic        gpio4_out_i,
  input  wire logic        gpio4_oe_n_i,
  output logic             shared_io_pin4_o,
  output logic             shared_io_pin4_oe_n,
  output logic             divided_clock_out,
  output logic      [7:0]  osc_trim_reg,
  output logic      [7:0]  ctrl_o,
  output logic             core_reset_o,
  output logic             core_stall_o
);
  import rts_pkg::*;

  localparam int DW = $clog2(RC_DIV + 1);
  localparam int PW = $clog2(POWERUP_DELAY_TIMER_TICKS + 1);
  localparam int OW = $clog2(OST_CYC + 1);
  localparam int FW = $clog2(FILT_CYC + 1);
  localparam int BW = $clog2(BOD_MIN_CYC + 1);

  // counters below need at least one step to count
  if (POWERUP_DELAY_TIMER_TICKS < 1 || RC_DIV < 1 || OST_CYC < 1 ||
      FILT_CYC < 1 || BOD_MIN_CYC < 1)
  begin : g_chk
    $error("rts_top: counts must be at least one");
  end

  function automatic logic is_xtal(input rts_mode_e m);
    is_xtal = (m == MODE_LP) || (m == MODE_XT) || (m == MODE_HS);
  endfunction

  function automatic logic is_ck(input rts_mode_e m);
    is_ck = (m == MODE_IOSC_CK) || (m == MODE_RC_CK);
  endfunction

  rts_state_e    st_q;
  rts_state_e    st_d;
  logic          xtal;
  logic          powerup_delay_timer_en;
  logic [DW-1:0] rc_div_q;
  logic          rc_tick;
  logic          osc1_q;
  logic          osc_rise;
  logic          ext_eff;
  logic [FW-1:0] filt_q;
  logic          ext_rst_q;
  logic [BW-1:0] bod_cnt_q;
  logic          bod_low;
  logic          bod_trip;
  logic [PW-1:0] powerup_delay_timer_q;
  logic          powerup_delay_timer_done;
  logic [OW-1:0] ost_q;
  logic          ost_done;
  logic          por_path_q;
  logic          wake_q;
  logic          core_reset_d;
  logic [1:0]    fdiv_q;
  logic          ps_bod_n_q;
  logic          ps_por_n_q;
  logic [7:0]    trim_q;
  logic [7:0]    ctrl_q;
  logic          ack_q;
  logic          req;
  logic          wr;
  logic [9:0]    idx;
  logic [31:0]   rd_d;

  assign xtal    = is_xtal(osc_mode_i);
  assign powerup_delay_timer_en = !powerup_delay_disable_n;

  // private rc oscillator stand-in: one tick per RC_DIV clocks
  assign rc_tick = (rc_div_q == DW'(RC_DIV - 1));
  always_ff @(posedge clk)
  begin
    if (sys_rst || rc_tick)
    begin
      rc_div_q <= '0;
    end
    else
    begin
      rc_div_q <= rc_div_q + DW'(1);
    end
  end

  // crystal input edge, taken as synchronous to clk
  assign osc_rise = osc1_i && !osc1_q;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      osc1_q <= 1'b0;
    end
    else
    begin
      osc1_q <= osc1_i;
    end
  end

  assign ext_eff = external_reset_pin_enable || external_reset_n;

  // pin must stay low FILT_CYC clocks
  always_ff @(posedge clk)
  begin
    if (sys_rst || ext_eff)
    begin
      filt_q    <= '0;
      ext_rst_q <= 1'b0;
    end
    else
    begin
      if (filt_q != FW'(FILT_CYC))
      begin
        filt_q <= filt_q + FW'(1);
      end
      ext_rst_q <= (filt_q >= FW'(FILT_CYC - 1));
    end
  end

  // trip only after more than the minimum low time
  assign bod_low  = brownout_enable && !vdd_above_bod_i;
  assign bod_trip = bod_low && (bod_cnt_q == BW'(BOD_MIN_CYC));
  always_ff @(posedge clk)
  begin
    if (sys_rst || !bod_low)
    begin
      bod_cnt_q <= '0;
    end
    else if (bod_cnt_q != BW'(BOD_MIN_CYC))
    begin
      bod_cnt_q <= bod_cnt_q + BW'(1);
    end
  end

  // delay counted in rc ticks, restarted on each entry
  assign powerup_delay_timer_done = rc_tick && (powerup_delay_timer_q == PW'(POWERUP_DELAY_TIMER_TICKS - 1));
  always_ff @(posedge clk)
  begin
    if (sys_rst || st_q != ST_POWERUP_DELAY_TIMER)
    begin
      powerup_delay_timer_q <= '0;
    end
    else if (rc_tick)
    begin
      powerup_delay_timer_q <= powerup_delay_timer_q + PW'(1);
    end
  end

  assign ost_done = osc_rise && (ost_q == OW'(OST_CYC - 1));
  always_ff @(posedge clk)
  begin
    if (sys_rst || st_q != ST_OST)
    begin
      ost_q <= '0;
    end
    else if (osc_rise)
    begin
      ost_q <= ost_q + OW'(1);
    end
  end

  // sequencer next state; the reset pin plays no part here
  // delays run from power-on, brown-out or a wake only
  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      ST_POR:
      begin
        if (vdd_por_ok_i && (!brownout_enable || vdd_above_bod_i))
        begin
          // power-up delay first, then start-up count
          if (powerup_delay_timer_en)
          begin
            st_d = ST_POWERUP_DELAY_TIMER;
          end
          else
          begin
            st_d = xtal ? ST_OST : ST_RUN;
          end
        end
      end
      ST_BOD:
      begin
        if (vdd_above_bod_i)
        begin
          st_d = powerup_delay_timer_en ? ST_POWERUP_DELAY_TIMER : ST_RUN;
        end
      end
      ST_POWERUP_DELAY_TIMER:
      begin
        if (bod_trip)
        begin
          st_d = ST_BOD;
        end
        else if (powerup_delay_timer_done)
        begin
          st_d = (por_path_q && xtal) ? ST_OST : ST_RUN;
        end
      end
      ST_OST:
      begin
        if (bod_trip)
        begin
          st_d = ST_BOD;
        end
        else if (ost_done)
        begin
          st_d = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (bod_trip)
        begin
          st_d = ST_BOD;
        end
        // wake from sleep in crystal modes
        else if (sleep_wake_i && xtal)
        begin
          st_d = ST_OST;
        end
      end
      default: st_d = ST_POR;
    endcase
  end

  // power-on state is left once; a falling supply never returns here
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_q <= ST_POR;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // remembers whether the sequence began at power-on, after a brown-out or from a wake
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      por_path_q <= 1'b1;
      wake_q     <= 1'b0;
    end
    else
    begin
      if (st_d == ST_BOD)
      begin
        por_path_q <= 1'b0;
      end
      wake_q <= (st_q == ST_RUN && st_d == ST_OST) ||
                (wake_q && st_d == ST_OST);
    end
  end

  // any source or running timer holds the core, except the start-up count after a wake; released on clk
  // watchdog only reaches the core, never the pin
  assign core_reset_d = !(st_q == ST_RUN || (st_q == ST_OST && wake_q)) ||
                        ext_rst_q || wdt_reset_i;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      core_reset_o <= 1'b1;
      core_stall_o <= 1'b0;
    end
    else
    begin
      core_reset_o <= core_reset_d;
      core_stall_o <= (st_q == ST_OST) && wake_q;
    end
  end

  // fosc/4 on the shared pin in clock-out modes
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      fdiv_q              <= 2'h0;
      divided_clock_out   <= 1'b0;
      shared_io_pin4_o    <= 1'b0;
      shared_io_pin4_oe_n <= 1'b1;
    end
    else
    begin
      fdiv_q            <= fdiv_q + 2'h1;
      divided_clock_out <= fdiv_q[1];
      if (is_ck(osc_mode_i))
      begin
        shared_io_pin4_o    <= fdiv_q[1];
        shared_io_pin4_oe_n <= 1'b0;
      end
      else
      begin
        // crystal modes keep the pin for the oscillator
        shared_io_pin4_o    <= gpio4_out_i;
        shared_io_pin4_oe_n <= xtal || gpio4_oe_n_i;
      end
    end
  end

  // classic wishbone slave, ack one clock after the strobe
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr  = req && wb_we_i && wb_sel_i[0];
  assign idx = wb_adr_i[11:2];
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ack_q    <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      ack_q <= req;
      if (req)
      begin
        wb_dat_o <= rd_d;
      end
    end
  end
  assign wb_ack_o = ack_q;

  // read mux; unmapped words and unused bits read zero
  always_comb
  begin
    rd_d = 32'h0;
    unique case (idx)
      PS_IDX:
      begin
        rd_d[PS_BOD_BIT] = ps_bod_n_q;
        rd_d[PS_POR_BIT] = ps_por_n_q;
      end
      TRIM_IDX: rd_d[7:0] = trim_q;
      CTRL_IDX: rd_d[7:0] = ctrl_q;
      STAT_IDX: rd_d[7:0] = {core_stall_o, ext_rst_q, bod_low, st_q};
      default:  rd_d = 32'h0;
    endcase
  end

  // hardware clear beats a software set in the same cycle
  // power-on clears both, a brown-out trip also clears the brown-out flag; written to one by software
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ps_bod_n_q <= PS_BOD_RST;
      ps_por_n_q <= PS_POR_RST;
    end
    else
    begin
      if (bod_trip)
      begin
        ps_bod_n_q <= 1'b0;
      end
      else if (wr && idx == PS_IDX)
      begin
        ps_bod_n_q <= wb_dat_i[PS_BOD_BIT];
      end
      if (wr && idx == PS_IDX)
      begin
        ps_por_n_q <= wb_dat_i[PS_POR_BIT];
      end
    end
  end

  // trim survives every reset except power-on
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      trim_q <= TRIM_RST;
    end
    else if (wr && idx == TRIM_IDX)
    begin
      trim_q <= wb_dat_i[7:0];
    end
  end
  assign osc_trim_reg = trim_q;

  // reloaded on every chip reset, kept through a wake
  always_ff @(posedge clk)
  begin
    if (sys_rst || core_reset_o)
    begin
      ctrl_q <= CTRL_RST;
    end
    else if (wr && idx == CTRL_IDX)
    begin
      ctrl_q <= wb_dat_i[7:0];
    end
  end
  assign ctrl_o = ctrl_q;

  // checks on the sequencer
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_por_hold: assert property (st_q == ST_POR |=> core_reset_o)
    else $error("core left reset during power-on wait");
  a_bod_restart: assert property (st_q == ST_POWERUP_DELAY_TIMER && bod_trip |=>
    st_q == ST_BOD ##1 powerup_delay_timer_q == '0)
    else $error("brown-out did not restart the power-up delay");
  a_powerup_delay_timer_skip: assert property (st_q == ST_BOD && vdd_above_bod_i &&
    powerup_delay_disable_n |=> st_q == ST_RUN)
    else $error("disabled delay still applied");
  a_powerup_delay_timer_len: assert property (st_q == ST_POWERUP_DELAY_TIMER && !bod_trip &&
    powerup_delay_timer_done |=> st_q != ST_POWERUP_DELAY_TIMER)
    else $error("power-up delay did not end on its count");
  a_ost_len: assert property (st_q == ST_OST && !bod_trip &&
    ost_done |=> st_q == ST_RUN)
    else $error("start-up count did not end at its count");
  a_ost_skip: assert property (st_q == ST_BOD |=>
    !por_path_q)
    else $error("brown-out path may still take start-up count");
  a_bod_flag: assert property (bod_trip |=> !ps_bod_n_q)
    else $error("brown-out flag not cleared");
  // power flag only changes by write
  a_por_flag: assert property (!(wr && idx == PS_IDX) |=>
    $stable(ps_por_n_q))
    else $error("power-on flag changed without a write");
  a_ext_filter: assert property ($rose(ext_rst_q) |->
    filt_q == FW'(FILT_CYC))
    else $error("pin reset taken before filter time");
  // release only from a settled state
  a_rel_sync: assert property ($fell(core_reset_o) |->
    $past(st_q == ST_RUN || st_q == ST_OST) && !$past(wdt_reset_i))
    else $error("core reset released while a source was active");
  a_divided_clock_out_pin: assert property (is_ck(osc_mode_i) |=>
    !shared_io_pin4_oe_n ##1 shared_io_pin4_o == divided_clock_out)
    else $error("clock-out pin not driven");

  c_por_run:  cover property (st_q == ST_POR ##[1:1000] st_q == ST_RUN);
  c_bod_powerup_delay_timer: cover property (st_q == ST_BOD ##1 st_q == ST_POWERUP_DELAY_TIMER);
  c_wake_ost: cover property (st_q == ST_RUN ##1 st_q == ST_OST && wake_q);
endmodule
`default_nettype wire

// file: hw/rts_pkg.sv
// constants, modes and states of the reset sequencer
// assumes a 20 MHz system clock
package rts_pkg;
  localparam int unsigned CLK_NS      = 50;
  localparam int unsigned NOM_OSC_HZ  = 4_000_000;
  localparam int unsigned POWERUP_DELAY_TIMER_MS     = 72;
  localparam int unsigned RC_TICK_NS  = 1000;
  localparam int unsigned RC_DIV      = RC_TICK_NS / CLK_NS;
  localparam int unsigned POWERUP_DELAY_TIMER_TICKS  = POWERUP_DELAY_TIMER_MS * 1_000_000 / RC_TICK_NS;
  localparam int unsigned OST_CYC     = 1024;
  localparam int unsigned BOD_MIN_NS  = 100;
  localparam int unsigned BOD_MIN_CYC = (BOD_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned FILT_NS     = 2000;
  localparam int unsigned FILT_CYC    = (FILT_NS + CLK_NS - 1) / CLK_NS;
  // register word indices; byte address is four times the index
  localparam logic [9:0] PS_IDX   = 10'h08E;
  localparam logic [9:0] TRIM_IDX = 10'h08F;
  localparam logic [9:0] CTRL_IDX = 10'h090;
  localparam logic [9:0] STAT_IDX = 10'h091;
  localparam int unsigned PS_BOD_BIT = 0;
  localparam int unsigned PS_POR_BIT = 1;
  localparam logic       PS_BOD_RST = 1'h0;
  localparam logic       PS_POR_RST = 1'h0;
  localparam logic [7:0] TRIM_RST   = 8'h00;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  typedef enum logic [2:0] {
    MODE_LP   = 3'h0, MODE_XT   = 3'h1, MODE_HS   = 3'h2, MODE_EC = 3'h3,
    MODE_IOSC = 3'h4, MODE_IOSC_CK = 3'h5, MODE_RC = 3'h6, MODE_RC_CK = 3'h7
  } rts_mode_e;
  typedef enum logic [4:0] {
    ST_POR  = 5'h01,
    ST_BOD  = 5'h02,
    ST_POWERUP_DELAY_TIMER = 5'h04,
    ST_OST  = 5'h08,
    ST_RUN  = 5'h10
  } rts_state_e;
endpackage

// file: tb/rts_partner.sv
// far-side model: supply detectors, reset pin driver and crystal on osc1
// assumes bench commands change just after rising clk edges
`timescale 1ns/1ps
`default_nettype none
module rts_partner (
  input  wire logic clk,
  input  wire logic por_cmd,
  input  wire logic bod_cmd,
  input  wire logic pin_cmd,
  output logic      vdd_por_ok_i,
  output logic      vdd_above_bod_i,
  output logic      external_reset_n,
  output var logic  osc1_i
);
  assign vdd_por_ok_i = por_cmd;
  assign vdd_above_bod_i = bod_cmd;
  // pin driven by a board switch
  assign external_reset_n = pin_cmd; // no pull-up, always driven
  initial osc1_i = 1'b0;
  always @(posedge clk)
  begin
    osc1_i <= por_cmd & ~osc1_i; // stands low while the supply is down
  end
endmodule
`default_nettype wire

// file: tb/rts_top_bench.sv
// self-checking bench for the reset sequencer over classic wishbone
// assumes shortened counts: delay 10 clocks, 8 crystal edges, filter 3
`timescale 1ns/1ps
`default_nettype none
module rts_top_bench;
  import rts_pkg::*;
  logic        clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [11:0] wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic        wb_ack_o, powerup_delay_disable_n, brownout_enable;
  logic        external_reset_pin_enable, external_reset_n, vdd_por_ok_i;
  logic        vdd_above_bod_i, wdt_reset_i, sleep_wake_i, osc1_i;
  logic        gpio4_out_i, gpio4_oe_n_i, shared_io_pin4_o, shared_io_pin4_oe_n;
  logic        divided_clock_out, core_reset_o, core_stall_o, por, brownout_flag_n, pin;
  logic [7:0]  osc_trim_reg, ctrl_o, b;
  rts_mode_e   osc_mode_i;
  int          miscompares, check_count, n;

  rts_top #(.POWERUP_DELAY_TIMER_TICKS(5), .RC_DIV(2), .OST_CYC(8), .FILT_CYC(3), .BOD_MIN_CYC(2)) uut (
    .clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .osc_mode_i, .powerup_delay_disable_n,
    .brownout_enable, .external_reset_pin_enable, .external_reset_n,
    .vdd_por_ok_i, .vdd_above_bod_i, .wdt_reset_i, .sleep_wake_i, .osc1_i,
    .gpio4_out_i, .gpio4_oe_n_i, .shared_io_pin4_o, .shared_io_pin4_oe_n,
    .divided_clock_out, .osc_trim_reg, .ctrl_o, .core_reset_o, .core_stall_o);
  rts_partner far (.clk, .por_cmd(por), .bod_cmd(brownout_flag_n), .pin_cmd(pin),
    .vdd_por_ok_i, .vdd_above_bod_i, .external_reset_n, .osc1_i);

  // 20 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  // one classic cycle, held until ack is sampled high
  task automatic wb_xfer(input logic w, input logic [9:0] idx, input logic [7:0] d);
    int t;
    t = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {idx, 2'h0};
    wb_dat_i <= {24'h0, d};
    wb_sel_i <= 4'hF;
    do
    begin
      @(posedge clk);
      t++;
    end
    while (wb_ack_o !== 1'b1 && t < 50);
    if (t >= 50)
      miscompares++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic chk_rd(input string nm, input logic [9:0] idx, input logic [31:0] e);
    wb_xfer(1'b0, idx, 8'h00);
    chk(nm, q, e);
  endtask

  // counts edges until core reset shows v, at most mx
  task automatic wait_rst(input logic v, input int mx, output int k);
    k = 0;
    while (core_reset_o !== v && k < mx)
    begin
      @(posedge clk);
      k++;
    end
  endtask

  // power-on event with the supply still rising
  task automatic power_up(input rts_mode_e m, input logic dn, input logic be);
    int k;
    @(posedge clk);
    osc_mode_i <= m;
    powerup_delay_disable_n <= dn;
    brownout_enable <= be; // delay left on with brown-out where it matters
    por <= 1'b0;
    brownout_flag_n <= 1'b0;
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    wait_rst(1'b0, 20, k);
    chk("rising supply hold", k, 20);
    por <= 1'b1;
    brownout_flag_n <= 1'b1;
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // watchdog: the whole run needs well under 2000 cycles
  initial
  begin
    #500_000;
    miscompares++;
    report_and_stop();
  end

  initial
  begin
    {sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {external_reset_pin_enable, wdt_reset_i, sleep_wake_i, gpio4_out_i} = '0;
    // reset pin idles high so the filter stays quiet until a test pulls it
    {gpio4_oe_n_i, pin, por, brownout_flag_n} = 4'hF;
    osc_mode_i = MODE_XT;
    {powerup_delay_disable_n, brownout_enable} = 2'h1;
    // crystal power-up: delay then start-up count
    power_up(MODE_XT, 1'b0, 1'b1);
    wait_rst(1'b0, 80, n);
    chk("xt start-up", n >= 26 && n <= 40, 1);
    chk_rd("flags after power-on", PS_IDX, 32'h0);
    wb_xfer(1'b1, PS_IDX, 8'h03); // software sets both flags
    chk_rd("flags set", PS_IDX, 32'h3);
    wb_xfer(1'b1, TRIM_IDX, 8'hA5); // software copies the trim literal
    chk("trim out", 32'(osc_trim_reg), 32'hA5);
    wb_xfer(1'b1, 10'h0A0, 8'hFF);
    chk_rd("unmapped", 10'h0A0, 32'h0);
    wb_xfer(1'b1, CTRL_IDX, 8'h5A);
    $display("test done: power-up and registers");
    // watchdog reset, then a wake from sleep
    @(posedge clk);
    wdt_reset_i <= 1'b1;
    @(posedge clk);
    wdt_reset_i <= 1'b0;
    wait_rst(1'b1, 4, n);
    chk("wdt reset", n < 4, 1);
    wait_rst(1'b0, 10, n);
    chk_rd("ctrl after wdt", CTRL_IDX, 32'h0);
    chk_rd("flags after wdt", PS_IDX, 32'h3);
    wb_xfer(1'b1, CTRL_IDX, 8'h3C);
    sleep_wake_i <= 1'b1;
    @(posedge clk);
    sleep_wake_i <= 1'b0;
    repeat (4) @(posedge clk);
    chk("stall on wake", {core_stall_o, core_reset_o}, 2'b10);
    repeat (30) @(posedge clk);
    chk_rd("ctrl kept on wake", CTRL_IDX, 32'h3C);
    $display("test done: watchdog and wake");
    // reset pin: short pulse, long pulse, pin disabled
    pin <= 1'b0;
    repeat (2) @(posedge clk);
    pin <= 1'b1;
    wait_rst(1'b1, 8, n);
    chk("short pulse", n, 8);
    pin <= 1'b0;
    wait_rst(1'b1, 10, n);
    chk("long pulse", n < 10, 1);
    pin <= 1'b1;
    wait_rst(1'b0, 6, n);
    chk("pin release", n < 6, 1);
    external_reset_pin_enable <= 1'b1;
    pin <= 1'b0;
    wait_rst(1'b1, 10, n);
    chk("pin ignored", n, 10);
    pin <= 1'b1;
    external_reset_pin_enable <= 1'b0;
    $display("test done: reset pin");
    // brown-out: short dip, trip, retrip during the delay
    brownout_flag_n <= 1'b0;
    @(posedge clk);
    brownout_flag_n <= 1'b1;
    wait_rst(1'b1, 6, n);
    chk("short dip", n, 6);
    brownout_flag_n <= 1'b0;
    repeat (4) @(posedge clk);
    chk_rd("flags on brown-out", PS_IDX, 32'h2);
    chk("held low supply", core_reset_o, 1);
    brownout_flag_n <= 1'b1;
    repeat (5) @(posedge clk);
    brownout_flag_n <= 1'b0;
    repeat (4) @(posedge clk);
    brownout_flag_n <= 1'b1;
    wait_rst(1'b0, 40, n);
    chk("brown-out recovery", n >= 10 && n <= 18, 1);
    $display("test done: brown-out");
    // external clock, delay off: no delay at all
    power_up(MODE_EC, 1'b1, 1'b1);
    wait_rst(1'b0, 8, n);
    chk("ec no delay", n < 8, 1);
    brownout_flag_n <= 1'b0;
    repeat (5) @(posedge clk);
    chk("ec brown-out held", core_reset_o, 1);
    brownout_flag_n <= 1'b1;
    wait_rst(1'b0, 6, n);
    chk("brown-out no delay", n < 6, 1);
    sleep_wake_i <= 1'b1;
    @(posedge clk);
    sleep_wake_i <= 1'b0;
    repeat (3) @(posedge clk);
    chk("no stall in ec", core_stall_o, 0);
    brownout_enable <= 1'b0;
    por <= 1'b0;
    brownout_flag_n <= 1'b0;
    wait_rst(1'b1, 10, n);
    chk("falling supply", n, 10);
    $display("test done: external clock");
    // clock output and plain io on pin4
    power_up(MODE_IOSC_CK, 1'b1, 1'b0);
    repeat (10) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      b[i] = shared_io_pin4_o;
    end
    chk("divided_clock_out period", {b[3:0] ^ b[7:4], b[1:0] ^ b[3:2]}, 6'h03);
    chk("divided_clock_out drive", shared_io_pin4_oe_n, 0);
    chk("divided_clock_out divided", divided_clock_out, b[7]);
    power_up(MODE_IOSC, 1'b1, 1'b0);
    gpio4_out_i <= 1'b1;
    gpio4_oe_n_i <= 1'b0;
    repeat (10) @(posedge clk);
    chk("pin4 as io", {shared_io_pin4_o, shared_io_pin4_oe_n}, 2'b10);
    $display("test done: clock output");
    // pin held low across the delays
    pin <= 1'b0;
    power_up(MODE_XT, 1'b0, 1'b1);
    repeat (60) @(posedge clk);
    chk("pin holds reset", core_reset_o, 1);
    pin <= 1'b1;
    wait_rst(1'b0, 6, n);
    chk("run at release", n < 6, 1);
    $display("test done: delays under pin");
    report_and_stop();
  end
endmodule
`default_nettype wire
